//--- rtl/i2c_adc_conversion_slave.sv
// What this block does
// R1 - power up with everything shut down
// R2 - track input only two scl cycles before conversion
// R3 - sar steps run on internal oscillator
// R4 - hold scl low until result ready
// R5 - hold result in register for readout
// R6 - one bit per scl, nine per byte
// R7 - sda stable while scl high
// R8 - idle bus left released by both
// R9 - detect start and stop conditions
// R10 - stop restores fast mode, restart keeps mode
// R11 - ack drives sda low over ninth pulse
// R12 - nack leaves sda released on ninth pulse
// R13 - idle device waits for start and address
// R14 - address is 011 plus four select pins
// R15 - read bit ignored with external reference
// R16 - ack valid address then start conversion
// R17 - fast timing after power up
// R18 - master code gets nack then high speed
// R19 - master uses restart after master code
// R20 - result returned msb byte then lsb byte
// R21 - convert again while master acknowledges
// R22 - master nack shuts reference when requested
// R23 - reference wakes on ninth address fall
// R24 - converter powered from address match or master ack until the result lands
// R25 - foreign address leaves sda released
// R26 - trailing sub-bits sent as zero
module i2c_adc_conversion_slave
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clk_conv,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        address_select_bit0,
  input  wire logic        address_select_bit1,
  input  wire logic        address_select_bit2,
  input  wire logic        address_select_bit3,
  input  wire logic        reference_adjust_pin,
  input  wire logic        comparator_keep,
  output logic [13:0]      dac_code,
  output logic             track_enable,
  output logic             adc_power,
  output logic             ref_power,
  output logic             hs_mode
);

  logic [6:0]                pin_meta;
  logic [6:0]                pin_sync;
  logic                      scl_prev;
  logic                      sda_prev;
  logic                      scl_s;
  logic                      sda_s;
  logic [3:0]                addr_sel;
  logic                      ref_ext;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_seen;
  logic                      stop_seen;
  i2c_adc_pkg::state_t       state;
  logic [3:0]                cnt;
  logic [7:0]                shreg;
  logic [7:0]                tx_sh;
  logic                      byte_sel;
  logic                      host_ack;
  logic                      hs_pending;
  logic                      rw_shutdown;
  logic                      conv_req;
  logic                      done_meta;
  logic                      done_sync;
  logic                      done_prev;
  logic                      done_edge;
  logic                      sar_done;
  logic [13:0]               sar_result;
  logic [13:0]               result_hold;
  logic                      addr_done;
  logic                      addr_ok;
  logic                      ack_end;
  logic                      host_end;
  logic                      conv_kick;
  logic                      conv_finish;

  // ************************************
  // helpers
  // ************************************
  function automatic logic addr_match(input logic [6:0] a, input logic [3:0] sel);
    addr_match = (a == {i2c_adc_pkg::ADDR_FIXED, sel});
  endfunction

  function automatic logic is_hs_code(input logic [7:0] b);
    is_hs_code = (b[7:3] == i2c_adc_pkg::HS_CODE_TOP);
  endfunction

  // ************************************
  // pin synchronisers
  // ************************************
  // open drain: we only ever pull low, the enable does the work
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  // every pin is asynchronous to clk_sys
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pin_meta <= i2c_adc_pkg::PIN_IDLE;
      pin_sync <= i2c_adc_pkg::PIN_IDLE;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      pin_meta <= {scl_in, sda_in, address_select_bit3, address_select_bit2,
                   address_select_bit1, address_select_bit0, reference_adjust_pin};
      pin_sync <= pin_meta;
      scl_prev <= pin_sync[6];
      sda_prev <= pin_sync[5];
    end
  end

  assign scl_s    = pin_sync[6];
  assign sda_s    = pin_sync[5];
  assign addr_sel = pin_sync[4:1];
  assign ref_ext  = pin_sync[0]; // adjust pin tied high selects external

  // ************************************
  // bus events
  // ************************************
  // sda moving while scl stays high is control, not data
  assign scl_rise   = scl_s & ~scl_prev;
  assign scl_fall   = ~scl_s & scl_prev;
  assign start_seen = scl_s & scl_prev & sda_prev & ~sda_s; // R9 R7
  assign stop_seen  = scl_s & scl_prev & ~sda_prev & sda_s; // R9 R7

  // byte boundaries, taken on scl falls; conv_finish comes from the done toggle instead
  assign addr_done   = scl_fall && state == i2c_adc_pkg::ST_ADDR
                       && cnt == i2c_adc_pkg::BYTE_RISES;
  assign addr_ok     = addr_done && addr_match(shreg[7:1], addr_sel);
  assign ack_end     = scl_fall && state == i2c_adc_pkg::ST_DEV_ACK
                       && cnt == i2c_adc_pkg::ACK_RISES;
  assign host_end    = scl_fall && state == i2c_adc_pkg::ST_HOST_ACK
                       && cnt == i2c_adc_pkg::ACK_RISES;
  assign conv_kick   = ack_end || (host_end && host_ack && byte_sel);
  assign conv_finish = done_edge && state == i2c_adc_pkg::ST_CONV;

  // ************************************
  // result crossing
  // ************************************
  // done is a toggle; the result word stays put until the next request
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
    end
    else
    begin
      done_meta <= sar_done;
      done_sync <= done_meta;
      done_prev <= done_sync;
    end
  end

  assign done_edge = done_sync ^ done_prev;

  // holding register keeps the low byte while the high byte goes out
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      result_hold <= 14'h0;
    else if (conv_finish)
      result_hold <= sar_result; // R5
  end

  adc_sar_engine i_sar
  (
    .clk_conv        (clk_conv),
    .reset           (reset),
    .conv_req        (conv_req),
    .comparator_keep (comparator_keep),
    .dac_code        (dac_code),
    .conv_done       (sar_done),
    .result          (sar_result)
  );

  // ************************************
  // protocol engine
  // ************************************
  // sda only changes after a sensed scl fall, so it is stable while high
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state        <= i2c_adc_pkg::ST_IDLE; // R13
      cnt          <= 4'h0;
      shreg        <= 8'h0;
      tx_sh        <= 8'h0;
      sda_oe       <= 1'b0;
      scl_oe       <= 1'b0;
      byte_sel     <= 1'b0;
      host_ack     <= 1'b0;
      hs_pending   <= 1'b0;
      track_enable <= 1'b0;
      conv_req     <= 1'b0;
    end
    else if (stop_seen)
    begin
      state        <= i2c_adc_pkg::ST_IDLE; // R8
      sda_oe       <= 1'b0;
      track_enable <= 1'b0;
      hs_pending   <= 1'b0;
    end
    else if (start_seen)
    begin
      state        <= i2c_adc_pkg::ST_ADDR; // R13
      cnt          <= 4'h0;
      sda_oe       <= 1'b0;
      track_enable <= 1'b0;
      hs_pending   <= 1'b0;
    end
    else
    begin
      unique case (state)
        i2c_adc_pkg::ST_IDLE:
        begin
          cnt <= 4'h0;
        end
        i2c_adc_pkg::ST_ADDR:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_s};
            cnt   <= cnt + 4'h1; // R6
          end
          else if (scl_fall && cnt == i2c_adc_pkg::TRACK_RISES)
          begin
            // tracking spans the read bit and the ack slot
            track_enable <= addr_match(shreg[6:0], addr_sel); // R2 R14
          end
          else if (addr_done)
          begin
            if (addr_match(shreg[7:1], addr_sel))
            begin
              state  <= i2c_adc_pkg::ST_DEV_ACK;
              sda_oe <= 1'b1; // R16 R11
            end
            else
            begin
              state        <= i2c_adc_pkg::ST_IGNORE; // R25
              hs_pending   <= is_hs_code(shreg); // R18 R12
              track_enable <= 1'b0;
            end
          end
        end
        i2c_adc_pkg::ST_DEV_ACK:
        begin
          if (scl_rise)
            cnt <= cnt + 4'h1;
          else if (ack_end)
          begin
            // sample held: scl already low, start stretching at once
            sda_oe       <= 1'b0;
            track_enable <= 1'b0; // R2
            scl_oe       <= 1'b1; // R4
            conv_req     <= ~conv_req; // R16
            state        <= i2c_adc_pkg::ST_CONV;
          end
        end
        i2c_adc_pkg::ST_IGNORE:
        begin
          // count only as far as the ack slot, the master code needs it
          if (scl_rise && cnt != i2c_adc_pkg::ACK_RISES)
            cnt <= cnt + 4'h1;
        end
        i2c_adc_pkg::ST_CONV:
        begin
          if (done_edge)
          begin
            // first bit goes onto sda in the same cycle that scl is let go
            tx_sh    <= sar_result[13:6]; // R20
            sda_oe   <= ~sar_result[13];
            scl_oe   <= 1'b0; // R4
            byte_sel <= 1'b0;
            cnt      <= 4'h0;
            state    <= i2c_adc_pkg::ST_TX;
          end
        end
        i2c_adc_pkg::ST_TX:
        begin
          if (scl_rise)
            cnt <= cnt + 4'h1; // R6
          else if (scl_fall && cnt == i2c_adc_pkg::BYTE_RISES)
          begin
            sda_oe <= 1'b0;
            state  <= i2c_adc_pkg::ST_HOST_ACK;
          end
          else if (scl_fall)
          begin
            tx_sh  <= {tx_sh[6:0], 1'b0};
            sda_oe <= ~tx_sh[6]; // R7
            if (byte_sel && cnt == i2c_adc_pkg::TRACK_RISES)
              track_enable <= 1'b1; // R2
          end
        end
        i2c_adc_pkg::ST_HOST_ACK:
        begin
          if (scl_rise)
          begin
            cnt      <= cnt + 4'h1;
            host_ack <= ~sda_s; // R11 R12
            if (sda_s)
              track_enable <= 1'b0;
          end
          else if (host_end && !host_ack)
          begin
            track_enable <= 1'b0;
            state        <= i2c_adc_pkg::ST_IGNORE; // R21
          end
          else if (host_end && !byte_sel)
          begin
            tx_sh    <= {result_hold[5:0], i2c_adc_pkg::SUB_BITS}; // R20 R26
            sda_oe   <= ~result_hold[5];
            byte_sel <= 1'b1;
            cnt      <= 4'h0;
            state    <= i2c_adc_pkg::ST_TX;
          end
          else if (host_end)
          begin
            track_enable <= 1'b0;
            scl_oe       <= 1'b1; // R21 R4
            conv_req     <= ~conv_req;
            state        <= i2c_adc_pkg::ST_CONV;
          end
        end
      endcase
    end
  end

  // ************************************
  // timing mode
  // ************************************
  // a restart leaves the mode alone so the master can talk fast
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      hs_mode <= 1'b0; // R17 R1
    else if (stop_seen)
      hs_mode <= 1'b0; // R10
    else if (hs_pending && scl_fall && state == i2c_adc_pkg::ST_IGNORE
             && cnt == i2c_adc_pkg::ACK_RISES)
      hs_mode <= 1'b1; // R18
  end

  // ************************************
  // power control
  // ************************************
  // converter is up from address match or the master's ack until the result lands
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      adc_power <= 1'b0; // R1
    else if (conv_finish)
      adc_power <= 1'b0; // R24
    else if (addr_ok || conv_kick)
      adc_power <= 1'b1; // R24
  end

  // read bit only matters with the internal reference
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ref_power   <= 1'b0; // R1
      rw_shutdown <= 1'b0;
    end
    else
    begin
      if (addr_ok)
        rw_shutdown <= ~shreg[0] & ~ref_ext; // R15
      if (host_end && !host_ack && rw_shutdown && !ref_ext)
        ref_power <= 1'b0; // R22
      else if (ack_end && !ref_ext)
        ref_power <= 1'b1; // R23
    end
  end

  // ************************************
  // checks
  // ************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  property p_idle_free;
    state == i2c_adc_pkg::ST_IDLE |-> !sda_oe && !scl_oe;
  endproperty
  a_idle_free: assert property (p_idle_free) else $error("idle bus driven"); // R8

  property p_hold_in_conv;
    scl_oe |-> !track_enable && state == i2c_adc_pkg::ST_CONV;
  endproperty
  a_hold_in_conv: assert property (p_hold_in_conv) else $error("tracking while stretching"); // R2

  property p_stretch;
    $rose(scl_oe) |-> scl_oe throughout (!done_edge [*2]);
  endproperty
  a_stretch: assert property (p_stretch) else $error("scl released early"); // R4

  property p_stop_fs;
    stop_seen |=> !hs_mode;
  endproperty
  a_stop_fs: assert property (p_stop_fs) else $error("stop kept high speed"); // R10

  property p_restart_keep;
    start_seen && hs_mode |=> hs_mode;
  endproperty
  a_restart_keep: assert property (p_restart_keep) else $error("restart dropped mode"); // R10

  property p_ack_addr;
    $rose(state == i2c_adc_pkg::ST_DEV_ACK) |->
      shreg[7:5] == i2c_adc_pkg::ADDR_FIXED && shreg[4:1] == addr_sel && sda_oe;
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("ack on wrong address"); // R14

  property p_hs_nack;
    $rose(hs_mode) |-> !sda_oe && !$past(sda_oe) && state == i2c_adc_pkg::ST_IGNORE;
  endproperty
  a_hs_nack: assert property (p_hs_nack) else $error("master code acknowledged"); // R18

  property p_conv_start;
    ack_end |=> state == i2c_adc_pkg::ST_CONV && scl_oe && !sda_oe;
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("no conversion after ack"); // R16

  property p_sub_zero;
    state == i2c_adc_pkg::ST_TX && byte_sel && cnt >= i2c_adc_pkg::TRACK_RISES |-> sda_oe;
  endproperty
  a_sub_zero: assert property (p_sub_zero) else $error("sub bit not zero"); // R26

  property p_ref_off;
    host_end && !host_ack && rw_shutdown && !ref_ext |=> !ref_power;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference not shut"); // R22

  property p_ref_on;
    ack_end && !ref_ext |=> ref_power;
  endproperty
  a_ref_on: assert property (p_ref_on) else $error("reference not woken"); // R23

  property p_adc_off;
    conv_finish |=> !adc_power ##1 !adc_power;
  endproperty
  a_adc_off: assert property (p_adc_off) else $error("converter left on"); // R24

  c_hs_entry: cover property ($rose(hs_mode));
  c_pair_out: cover property (host_end && host_ack && byte_sel);
  c_ref_down: cover property ($fell(ref_power));

endmodule

//--- rtl/i2c_adc_pkg.sv
package i2c_adc_pkg;

  // ************************************
  // bus framing
  // ************************************
  localparam logic [2:0] ADDR_FIXED  = 3'h3;  // upper address bits 011
  localparam logic [4:0] HS_CODE_TOP = 5'h01; // master code 0000 1xxx
  localparam logic [3:0] TRACK_RISES = 4'h7;  // rises before tracking
  localparam logic [3:0] BYTE_RISES  = 4'h8;
  localparam logic [3:0] ACK_RISES   = 4'h9;
  localparam logic [6:0] PIN_IDLE    = 7'h7f;

  // ************************************
  // conversion
  // ************************************
  localparam int         RESULT_W   = 14;
  localparam logic [3:0] SAR_MSB    = 4'hd;
  localparam logic [13:0] SAR_FIRST = 14'h2000;
  localparam logic [1:0] SUB_BITS   = 2'h0;  // trailing sub-bits

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_DEV_ACK,
    ST_IGNORE,
    ST_CONV,
    ST_TX,
    ST_HOST_ACK
  } state_t;

endpackage

//--- rtl/adc_sar_engine.sv
// successive approximation sequencer on the conversion oscillator
module adc_sar_engine
(
  input  wire logic        clk_conv,
  input  wire logic        reset,
  input  wire logic        conv_req,
  input  wire logic        comparator_keep,
  output logic [13:0]      dac_code,
  output logic             conv_done,
  output logic [13:0]      result
);

  logic        rst_meta;
  logic        rst_conv;
  logic        req_meta;
  logic        req_sync;
  logic        req_prev;
  logic        busy;
  logic [3:0]  step;
  logic [13:0] next_code;

  // ************************************
  // crossings into the oscillator domain
  // ************************************
  // reset and the request toggle both come from clk_sys
  always_ff @(posedge clk_conv)
  begin
    rst_meta <= reset;
    rst_conv <= rst_meta;
    req_meta <= conv_req;
    req_sync <= req_meta;
  end

  // ************************************
  // bit trial
  // ************************************
  // drop the trial bit if the comparator rejects it, then try the next
  always_comb
  begin
    next_code = dac_code;
    if (!comparator_keep)
      next_code[step] = 1'b0;
    if (step != 4'h0)
      next_code[step - 4'h1] = 1'b1;
  end

  // one bit per oscillator cycle, independent of scl
  always_ff @(posedge clk_conv)
  begin
    if (rst_conv)
    begin
      req_prev  <= 1'b0;
      busy      <= 1'b0;
      step      <= 4'h0;
      dac_code  <= 14'h0;
      conv_done <= 1'b0;
      result    <= 14'h0;
    end
    else
    begin
      req_prev <= req_sync;
      if (!busy && (req_sync ^ req_prev))
      begin
        busy     <= 1'b1; // R3
        step     <= i2c_adc_pkg::SAR_MSB;
        dac_code <= i2c_adc_pkg::SAR_FIRST;
      end
      else if (busy)
      begin
        dac_code <= next_code;
        step     <= step - 4'h1;
        if (step == 4'h0)
        begin
          busy      <= 1'b0;
          result    <= next_code; // R5
          conv_done <= ~conv_done;
        end
      end
    end
  end

  // ************************************
  // checks
  // ************************************
  property p_sar_len;
    @(posedge clk_conv) disable iff (rst_conv)
    $rose(busy) |-> ##13 busy ##1 !busy;
  endproperty
  a_sar_len: assert property (p_sar_len) else $error("sar length wrong"); // R3

  property p_result_done;
    @(posedge clk_conv) disable iff (rst_conv)
    $changed(result) |-> $changed(conv_done) && !busy;
  endproperty
  a_result_done: assert property (p_result_done) else $error("result moved mid conversion"); // R5

  c_sar_run: cover property (@(posedge clk_conv) disable iff (rst_conv) $fell(busy));

endmodule

//--- verif/i2c_master_model.sv
// **********************************
// bus master partner on open-drain lines
// **********************************
module i2c_master_model
(
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 152; // scl period 4*Q stays under 1.7 MHz; multiple of 8 keeps changes on falling clk_sys
  int held;

  // idle: both lines released, pull-ups give high
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    held = 0;
  end

  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_low = 1'b0;
    #Q scl_low = 1'b0;
    #(2*Q) sda_low = 1'b1;
    #(2*Q) scl_low = 1'b1;
    #Q;
  endtask

  // stop: sda rises while scl is high
  task automatic stop();
    sda_low = 1'b1;
    #Q scl_low = 1'b0;
    #(2*Q) sda_low = 1'b0;
    #(2*Q);
  endtask

  // one bit a clock; sda moves only while scl is low, a stretched scl is waited out
  task automatic bit_xfer(input logic b, output logic r);
    sda_low = ~b;
    #Q scl_low = 1'b0;
    for (int n = 0; n < 2000 && scl !== 1'b1; n++)
    begin
      #8 held++;
    end
    #Q r = sda;
    #Q scl_low = 1'b1;
    #Q;
  endtask

  // address byte out, acknowledge slot read back
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], r);
    bit_xfer(1'b1, ack);
  endtask

  // data byte in, then our own acknowledge or not-acknowledge
  task automatic fetch(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(nack, r);
  endtask
endmodule

//--- verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, clk_conv, reset, ref_ext, keep, a;
  logic        scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda;
  logic        track_enable, adc_power, ref_power, hs_mode;
  logic [3:0]  sel;
  logic [7:0]  d;
  logic [13:0] target, dac_code;
  wire         scl, sda;
  int          bad_count, n_tests, trk;

  // **********************************
  // wires, analog stand-in, clocks
  // **********************************
  // pull-ups: a line is low only while a party drives it
  assign scl = ~(m_scl | (scl_oe & ~scl_out));
  assign sda = ~(m_sda | (sda_oe & ~sda_out));
  // comparator keeps a trial bit while the input sits at or above it, so the result equals target
  assign keep = dac_code <= target;

  i2c_adc_conversion_slave dut
  (
    .clk_sys(clk_sys), .reset(reset), .clk_conv(clk_conv), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_bit0(sel[0]), .address_select_bit1(sel[1]), .address_select_bit2(sel[2]),
    .address_select_bit3(sel[3]), .reference_adjust_pin(ref_ext), .comparator_keep(keep),
    .dac_code(dac_code), .track_enable(track_enable), .adc_power(adc_power),
    .ref_power(ref_power), .hs_mode(hs_mode)
  );

  i2c_master_model master
  (
    .scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // conversion oscillator, free running and out of phase with clk_sys
  initial
  begin
    clk_conv = 1'b0;
    #13;
    forever #40 clk_conv = ~clk_conv;
  end

  // count scl rises seen while the input is tracked
  always @(posedge scl)
    if (track_enable === 1'b1)
      trk++;

  // **********************************
  // checks and bus sequences
  // **********************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic addr(input logic [7:0] b, input logic exp_ack);
    trk = 0;
    master.start();
    master.send(b, a);
    chk("address ack", {15'h0, exp_ack}, {15'h0, a});
  endtask

  // one result pair; nxt is the input level for any conversion the pair kicks off
  task automatic pair(input logic [13:0] v, input logic nack, input logic [13:0] nxt);
    master.held = 0;
    trk = 0;
    master.fetch(1'b0, d);
    chk("stretch", 16'h1, {15'h0, master.held >= 100});
    chk("high byte", {8'h0, v[13:6]}, {8'h0, d});
    target = nxt;
    master.fetch(nack, d);
    chk("low byte", {8'h0, v[5:0], 2'h0}, {8'h0, d});
  endtask

  // **********************************
  // main sequence
  // **********************************
  initial
  begin
    reset = 1'b1;
    ref_ext = 1'b0;
    sel = 4'ha;
    target = 14'h2a5c;
    bad_count = 0;
    n_tests = 0;
    trk = 0;
    // the conversion side's reset synchroniser carries this pulse onto its own edges
    repeat (8) @(negedge clk_sys);
    chk("reset outputs", 16'h0, {10'h0, scl_oe, sda_oe, track_enable, adc_power, ref_power, hs_mode});
    reset = 1'b0;
    repeat (4) @(negedge clk_sys);
    // continuous conversion with internal reference and read bit set
    addr({3'h3, 4'ha, 1'b1}, 1'b0);
    chk("tracking rises", 16'h2, trk[15:0]);
    chk("power at address", 16'h3, {14'h0, adc_power, ref_power});
    pair(14'h2a5c, 1'b0, 14'h0777);
    chk("tracking rises", 16'h2, trk[15:0]);
    pair(14'h0777, 1'b1, 14'h0777);
    master.stop();
    chk("power after nack", 16'h1, {14'h0, adc_power, ref_power});
    $display("test 1 done");
    // foreign address is ignored and sda stays released
    addr({3'h3, 4'h5, 1'b1}, 1'b1);
    master.fetch(1'b1, d);
    chk("released sda", 16'h00ff, {8'h0, d});
    master.stop();
    chk("no power", 16'h0, {15'h0, adc_power});
    $display("test 2 done");
    // read bit clear asks for reference shutdown at the master nack
    target = 14'h3fff;
    addr({3'h3, 4'ha, 1'b0}, 1'b0);
    pair(14'h3fff, 1'b1, 14'h3fff);
    master.stop();
    chk("reference off", 16'h0, {15'h0, ref_power});
    $display("test 3 done");
    // master code, repeated start keeps high speed, stop drops it; external reference ignores read bit
    sel = 4'h3;
    ref_ext = 1'b1;
    target = 14'h0001;
    repeat (8) @(negedge clk_sys);
    addr(8'h0d, 1'b1);
    chk("high speed", 16'h1, {15'h0, hs_mode});
    addr({3'h3, 4'h3, 1'b0}, 1'b0);
    pair(14'h0001, 1'b1, 14'h0001);
    chk("speed kept", 16'h1, {15'h0, hs_mode});
    chk("external reference", 16'h0, {15'h0, ref_power});
    master.stop();
    repeat (8) @(negedge clk_sys);
    chk("speed after stop", 16'h0, {15'h0, hs_mode});
    $display("test 4 done");
    conclude();
  end

  // watchdog: several times the span the whole sequence should need
  initial
  begin
    #600000;
    bad_count++;
    $display("unexpected watchdog: expected done seen hang");
    conclude();
  end
endmodule
